// ==== sier_pkg.sv ====
// shared constants and types for the interrupt and error report block
package sier_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_STATUS = 6'h02;
	localparam logic [5:0] IDX_CODE = 6'h04;
	localparam logic [5:0] IDX_STEP = 6'h05;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h06;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h07;
	localparam logic [5:0] IDX_CONTROL = 6'h08;
	// controller_status bit positions
	localparam int ST_PENDING = 0;
	localparam int ST_ATN = 1;
	localparam int ST_DATA_REQ = 2;
	localparam int ST_SUSPEND = 3;
	// sticky interrupt bits
	localparam int IRQ_W = 3;
	localparam int IRQ_REPORT = 0;
	localparam int IRQ_OFFSET = 1;
	localparam int IRQ_TIMEOUT = 2;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
	// control bits
	localparam int CTL_PAUSE = 0;
	// interrupt codes
	localparam logic [7:0] CODE_CDB_MSG = 8'ha8;
	localparam logic [7:0] CODE_ID_CDB_MSG = 8'ha9;
	localparam logic [7:0] CODE_CDB_ATN = 8'haa;
	localparam logic [7:0] CODE_PAUSE_DONE = 8'h67;
	localparam logic [7:0] CODE_OFFSET_ERR = 8'h29;
	// value arbitrary, code not given
	localparam logic [7:0] CODE_HS_TIMEOUT = 8'h2a;
	// value arbitrary, code not given
	localparam logic [7:0] CODE_PHASE_ERR = 8'h2b;
	localparam logic [7:0] STEP_READY = 8'h00;
	// report queue
	localparam int RQ_DEPTH = 4;
	localparam int RQ_AW = 2;
	localparam int RQ_W = 16;
	localparam logic [RQ_AW:0] RQ_FULL = 3'h4;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// operating state of the controller when an event occurs
	typedef enum logic [1:0] {
		OP_DISCRETE,
		OP_USER_PROG,
		OP_AUTO_SEL,
		OP_READY
	} sier_op_e;
endpackage

// ==== sier_report_mem.sv ====
// report queue storage with registered read and write-through bypass
`timescale 1ns/1ps
`default_nettype none
module sier_report_mem (
	// clock
	input wire logic aclk,
	// write port
	input wire logic we,
	input wire logic [sier_pkg::RQ_AW-1:0] waddr,
	input wire logic [sier_pkg::RQ_W-1:0] wdata,
	// read port
	input wire logic [sier_pkg::RQ_AW-1:0] raddr,
	output logic [sier_pkg::RQ_W-1:0] rdata
);
	logic [sier_pkg::RQ_W-1:0] mem [sier_pkg::RQ_DEPTH];

	always_ff @(posedge aclk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end

	// bypass so an entry pushed into an empty queue shows one cycle later
	always_ff @(posedge aclk)
	begin
		if (we && (waddr == raddr))
		begin
			rdata <= wdata;
		end
		else
		begin
			rdata <= mem[raddr];
		end
	end
endmodule // sier_report_mem
`default_nettype wire

// ==== sier_scsi_model.sv ====
// sequencer-side model: event pulses and the answer to a pause request
`timescale 1ns/1ps
`default_nettype none
module sier_scsi_model (
	// clock
	input wire logic aclk,
	// pause request from the block
	input wire logic pause_req,
	// event pulses towards the block
	output logic [11:0] ev
);
	int lag = 3;
	int cnt = 0;
	initial ev = 12'h000;
	task automatic fire(input logic [11:0] m);
		@(posedge aclk);
		ev <= m;
		@(posedge aclk);
		ev <= 12'h000;
	endtask
	// transfer halts some cycles after a pause: pause end and transfer end arrive together
	always @(posedge aclk)
	begin
		if (pause_req)
			cnt <= lag;
		else if (cnt > 0)
			cnt <= cnt - 1;
		if (cnt == 1)
			ev <= 12'h900;
		else if (cnt == 0 && ev == 12'h900)
			ev <= 12'h000;
	end
endmodule // sier_scsi_model
`default_nettype wire

// ==== sier_top.sv ====
// interrupt code, command step and transfer error reporting with an axi4-lite register slave
//
// What this block does
// R1 - after selection, identify then command then an attention message gives code a9 in auto response.
// R2 - a command taken without attention at selection, followed by an attention condition, gives code aa.
// R3 - each report carries a code at index 04 and a step at index 05, and the host reads both.
// R4 - in discrete or sequential commands the step holds the command step low with the high nibble zero.
// R5 - in user program operation the high nibble counts completed commands, the low nibble the step.
// R6 - in auto selection response the high nibble is the sequence type, the low nibble the step.
// R7 - reports raised in the ready state carry a step of 00.
// R8 - a req/ack handshake timeout suspends the transfer and reports a timeout, in either role.
// R9 - an initiator offset error raises atn at once and reports at transfer end or on message out.
// R10 - an initiator leaving to a phase other than message out reports offset and phase errors.
// R11 - a target offset error suspends the transfer, terminates, then reports the offset error.
// R12 - an initiator data-in overrun with the data register full flags offset error and atn without stopping.
// R13 - the host detects the overrun when data request or dma_request_line stays low past its wait time.
// R14 - on the overrun the host pauses the transfer and services any transfer that resumes.
// R15 - after a pause the pause-complete report 67 comes before the offset error report 29.
// R16 - command then attention message without identify gives code a8 in auto response.
// R17 - code and step stay unchanged from raising until the host has read them.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module sier_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// operating state from the sequencer
	input wire sier_pkg::sier_op_e op_state,
	input wire logic [3:0] cmd_step,
	input wire logic [3:0] done_count,
	input wire logic [3:0] resp_type,
	input wire logic data_request,
	// selection response events
	input wire logic sel_start,
	input wire logic sel_atn,
	input wire logic identify_rx,
	input wire logic cdb_rx,
	input wire logic atn_msg_rx,
	input wire logic atn_detect,
	input wire logic ready_event,
	input wire logic [7:0] ready_code,
	// transfer events
	input wire logic is_initiator,
	input wire logic data_phase,
	input wire logic data_in_phase,
	input wire logic hs_timeout,
	input wire logic offset_err,
	input wire logic req_over_offset,
	input wire logic data_reg_full,
	input wire logic xfer_done,
	input wire logic phase_change,
	input wire logic to_msg_out,
	input wire logic terminate_done,
	input wire logic pause_done,
	// outputs to the bus sequencer, and the interrupt to the host
	output logic atn_out,
	output logic suspend_out,
	output logic terminate_start,
	output logic pause_req,
	output logic irq
);
	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_PAUSE,
		SRC_OFFSET,
		SRC_PHASE,
		SRC_TIMEOUT,
		SRC_AUTO,
		SRC_READY
	} sier_src_e;

	logic aw_got_reg, w_got_reg, wr_do, rd_hs, pop, push;
	logic [5:0] aw_idx_reg;
	logic [31:0] w_data_reg;
	logic w_lane0_reg;
	logic [31:0] rd_word;
	logic rd_ok;
	logic [sier_pkg::IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_set;
	logic pend_pause_reg, pend_offset_reg, pend_phase_reg, pend_timeout_reg, pend_auto_reg, pend_ready_reg;
	logic [7:0] auto_code_reg, auto_step_reg, ready_code_reg;
	logic identify_seen_reg, cdb_seen_reg, off_active_reg;
	sier_src_e push_src;
	logic [sier_pkg::RQ_W-1:0] push_data, head;
	logic [sier_pkg::RQ_AW-1:0] rd_ptr_reg, wr_ptr_reg, rd_ptr_next;
	logic [sier_pkg::RQ_AW:0] count_reg;
	logic init_off, targ_off, overrun;

	// step by operating state
	function automatic logic [7:0] step_of(input sier_pkg::sier_op_e st, input logic [3:0] step,
		input logic [3:0] cnt, input logic [3:0] rtype);
		logic [7:0] v;
		v = sier_pkg::STEP_READY;
		unique case (st)
			sier_pkg::OP_DISCRETE: v = {4'h0, step}; // [R4]
			sier_pkg::OP_USER_PROG: v = {cnt, step}; // [R5]
			sier_pkg::OP_AUTO_SEL: v = {rtype, step}; // [R6]
			sier_pkg::OP_READY: v = sier_pkg::STEP_READY; // [R7]
		endcase
		return v;
	endfunction

	// write address and data are taken independently
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b0;
			aw_got_reg <= 1'b0;
			aw_idx_reg <= 6'h00;
		end
		else if (bvalid && bready)
		begin
			aw_got_reg <= 1'b0;
			awready <= 1'b1;
		end
		else if (awvalid && awready)
		begin
			aw_got_reg <= 1'b1;
			aw_idx_reg <= awaddr[7:2];
			awready <= 1'b0;
		end
		else if (!aw_got_reg && !bvalid)
		begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wready <= 1'b0;
			w_got_reg <= 1'b0;
			w_data_reg <= 32'h0;
			w_lane0_reg <= 1'b0;
		end
		else if (bvalid && bready)
		begin
			w_got_reg <= 1'b0;
			wready <= 1'b1;
		end
		else if (wvalid && wready)
		begin
			w_got_reg <= 1'b1;
			w_data_reg <= wdata;
			w_lane0_reg <= wstrb[0];
			wready <= 1'b0;
		end
		else if (!w_got_reg && !bvalid)
		begin
			wready <= 1'b1;
		end
	end

	assign wr_do = aw_got_reg && w_got_reg && !bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp <= sier_pkg::RESP_OKAY;
		end
		else if (wr_do)
		begin
			bvalid <= 1'b1;
			bresp <= (aw_idx_reg == sier_pkg::IDX_IRQ_STAT || aw_idx_reg == sier_pkg::IDX_IRQ_MASK ||
				aw_idx_reg == sier_pkg::IDX_CONTROL) ? sier_pkg::RESP_OKAY : sier_pkg::RESP_SLVERR;
		end
		else if (bready)
		begin
			bvalid <= 1'b0;
		end
	end

	// read mux
	always_comb
	begin
		rd_word = 32'h0;
		rd_ok = 1'b1;
		unique case (araddr[7:2])
			sier_pkg::IDX_STATUS:
			begin
				rd_word[sier_pkg::ST_PENDING] = (count_reg != '0);
				rd_word[sier_pkg::ST_ATN] = atn_out;
				rd_word[sier_pkg::ST_DATA_REQ] = data_request;
				rd_word[sier_pkg::ST_SUSPEND] = suspend_out;
			end
			sier_pkg::IDX_CODE: rd_word[7:0] = (count_reg != '0) ? head[15:8] : 8'h00; // [R3]
			sier_pkg::IDX_STEP: rd_word[7:0] = (count_reg != '0) ? head[7:0] : 8'h00; // [R3]
			sier_pkg::IDX_IRQ_STAT: rd_word[sier_pkg::IRQ_W-1:0] = irq_stat_reg;
			sier_pkg::IDX_IRQ_MASK: rd_word[sier_pkg::IRQ_W-1:0] = irq_mask_reg;
			sier_pkg::IDX_CONTROL: rd_word = 32'h0;
			default: rd_ok = 1'b0;
		endcase
	end

	assign rd_hs = arvalid && arready;
	// reading the step retires the report, so the code is read first
	assign pop = rd_hs && (araddr[7:2] == sier_pkg::IDX_STEP) && (count_reg != '0); // [R17]

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= sier_pkg::RESP_OKAY;
		end
		else if (rd_hs)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_ok ? sier_pkg::RESP_OKAY : sier_pkg::RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
		else if (!rvalid)
		begin
			arready <= 1'b1;
		end
	end

	// selection response tracking
	always_ff @(posedge aclk)
	begin
		if (!aresetn || sel_start)
		begin
			identify_seen_reg <= 1'b0;
			cdb_seen_reg <= 1'b0;
		end
		else
		begin
			if (identify_rx)
				identify_seen_reg <= 1'b1;
			if (cdb_rx)
				cdb_seen_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pend_auto_reg <= 1'b0;
			auto_code_reg <= 8'h00;
			auto_step_reg <= 8'h00;
		end
		else if (op_state == sier_pkg::OP_AUTO_SEL && cdb_seen_reg && atn_msg_rx)
		begin
			pend_auto_reg <= 1'b1;
			auto_code_reg <= identify_seen_reg ? sier_pkg::CODE_ID_CDB_MSG : sier_pkg::CODE_CDB_MSG; // [R1] [R16]
			auto_step_reg <= step_of(op_state, cmd_step, done_count, resp_type);
		end
		else if (op_state == sier_pkg::OP_AUTO_SEL && cdb_seen_reg && !sel_atn && atn_detect)
		begin
			pend_auto_reg <= 1'b1;
			auto_code_reg <= sier_pkg::CODE_CDB_ATN; // [R2]
			auto_step_reg <= step_of(op_state, cmd_step, done_count, resp_type);
		end
		else if (push_src == SRC_AUTO)
		begin
			pend_auto_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pend_ready_reg <= 1'b0;
			ready_code_reg <= 8'h00;
		end
		else if (ready_event)
		begin
			pend_ready_reg <= 1'b1;
			ready_code_reg <= ready_code;
		end
		else if (push_src == SRC_READY)
		begin
			pend_ready_reg <= 1'b0;
		end
	end

	// transfer error handling
	assign init_off = is_initiator && data_phase && offset_err;
	assign overrun = is_initiator && data_in_phase && req_over_offset && data_reg_full;
	assign targ_off = !is_initiator && data_phase && offset_err;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			atn_out <= 1'b0;
			off_active_reg <= 1'b0;
		end
		else if (init_off || overrun)
		begin
			atn_out <= 1'b1; // [R9] [R12]
			off_active_reg <= 1'b1;
		end
		else if (off_active_reg && (xfer_done || phase_change))
		begin
			off_active_reg <= 1'b0;
		end
		else if (!off_active_reg && phase_change)
		begin
			atn_out <= 1'b0;
		end
	end

	// overrun keeps running; only timeout, target offset and pause suspend
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			suspend_out <= 1'b0;
			terminate_start <= 1'b0;
		end
		else
		begin
			terminate_start <= targ_off; // [R11]
			if (hs_timeout || targ_off || pause_req) // [R8] [R11]
				suspend_out <= 1'b1;
			else if (sel_start)
				suspend_out <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pause_req <= 1'b0;
		else
			pause_req <= wr_do && aw_idx_reg == sier_pkg::IDX_CONTROL && w_lane0_reg &&
				w_data_reg[sier_pkg::CTL_PAUSE];
	end

	// pending reports; a new event wins over the clear by push
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pend_pause_reg <= 1'b0;
			pend_offset_reg <= 1'b0;
			pend_phase_reg <= 1'b0;
			pend_timeout_reg <= 1'b0;
		end
		else
		begin
			pend_pause_reg <= pause_done || (pend_pause_reg && push_src != SRC_PAUSE); // [R15]
			pend_offset_reg <= (off_active_reg && (xfer_done || phase_change)) || (!is_initiator && terminate_done) ||
				(pend_offset_reg && push_src != SRC_OFFSET); // [R9] [R11]
			pend_phase_reg <= (off_active_reg && phase_change && !to_msg_out) ||
				(pend_phase_reg && push_src != SRC_PHASE); // [R10]
			pend_timeout_reg <= hs_timeout || (pend_timeout_reg && push_src != SRC_TIMEOUT); // [R8]
		end
	end

	// one report per cycle; pause complete ahead of the offset error
	always_comb
	begin
		push_src = SRC_NONE;
		push_data = '0;
		if (count_reg != sier_pkg::RQ_FULL)
		begin
			if (pend_pause_reg)
			begin
				push_src = SRC_PAUSE; // [R15]
				push_data = {sier_pkg::CODE_PAUSE_DONE, step_of(op_state, cmd_step, done_count, resp_type)};
			end
			else if (pend_offset_reg)
			begin
				push_src = SRC_OFFSET;
				push_data = {sier_pkg::CODE_OFFSET_ERR, step_of(op_state, cmd_step, done_count, resp_type)};
			end
			else if (pend_phase_reg)
			begin
				push_src = SRC_PHASE; // [R10]
				push_data = {sier_pkg::CODE_PHASE_ERR, step_of(op_state, cmd_step, done_count, resp_type)};
			end
			else if (pend_timeout_reg)
			begin
				push_src = SRC_TIMEOUT;
				push_data = {sier_pkg::CODE_HS_TIMEOUT, step_of(op_state, cmd_step, done_count, resp_type)};
			end
			else if (pend_auto_reg)
			begin
				push_src = SRC_AUTO;
				push_data = {auto_code_reg, auto_step_reg};
			end
			else if (pend_ready_reg)
			begin
				push_src = SRC_READY;
				push_data = {ready_code_reg, sier_pkg::STEP_READY}; // [R7]
			end
		end
	end

	assign push = (push_src != SRC_NONE);
	assign rd_ptr_next = pop ? rd_ptr_reg + 2'h1 : rd_ptr_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_ptr_reg <= '0;
			wr_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			rd_ptr_reg <= rd_ptr_next;
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 2'h1;
			count_reg <= count_reg + {2'h0, push} - {2'h0, pop};
		end
	end

	sier_report_mem u_mem (
		.aclk(aclk),
		.we(push),
		.waddr(wr_ptr_reg),
		.wdata(push_data),
		.raddr(rd_ptr_next),
		.rdata(head)
	);

	// sticky interrupt bits, write one to clear, set wins
	always_comb
	begin
		irq_set = '0;
		irq_set[sier_pkg::IRQ_REPORT] = push;
		irq_set[sier_pkg::IRQ_OFFSET] = (push_src == SRC_OFFSET);
		irq_set[sier_pkg::IRQ_TIMEOUT] = (push_src == SRC_TIMEOUT);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_stat_reg <= '0;
			irq_mask_reg <= sier_pkg::IRQ_MASK_RST;
			irq <= 1'b0;
		end
		else
		begin
			if (wr_do && aw_idx_reg == sier_pkg::IDX_IRQ_STAT && w_lane0_reg)
				irq_stat_reg <= (irq_stat_reg & ~w_data_reg[sier_pkg::IRQ_W-1:0]) | irq_set;
			else
				irq_stat_reg <= irq_stat_reg | irq_set;
			if (wr_do && aw_idx_reg == sier_pkg::IDX_IRQ_MASK && w_lane0_reg)
				irq_mask_reg <= w_data_reg[sier_pkg::IRQ_W-1:0];
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_id_cdb;
		identify_seen_reg && cdb_seen_reg && op_state == sier_pkg::OP_AUTO_SEL;
	endsequence
	sequence s_off_pending;
		off_active_reg && phase_change && !to_msg_out;
	endsequence

	a_code_a9: assert property ((s_id_cdb and atn_msg_rx && !sel_start) |=> // [R1]
		pend_auto_reg && auto_code_reg == 8'ha9) else $error("a9 not reported");
	a_code_aa: assert property ((cdb_seen_reg && op_state == sier_pkg::OP_AUTO_SEL && !sel_atn && atn_detect // [R2]
		&& !atn_msg_rx && !sel_start) |=> auto_code_reg == 8'haa) else $error("aa not reported");
	a_discrete_nibble: assert property ((push && op_state == sier_pkg::OP_DISCRETE && push_src != SRC_AUTO // [R4]
		&& push_src != SRC_READY) |-> push_data[7:4] == 4'h0) else $error("step high nibble not zero");
	a_ready_step: assert property ((push_src == SRC_READY) |-> push_data[7:0] == 8'h00) // [R7]
		else $error("ready step not zero");
	a_timeout_suspend: assert property (hs_timeout |=> suspend_out && pend_timeout_reg) // [R8]
		else $error("timeout not handled");
	a_init_atn: assert property (init_off |=> atn_out ##1 atn_out || !off_active_reg) // [R9]
		else $error("atn not raised");
	a_phase_both: assert property (s_off_pending |=> pend_offset_reg && pend_phase_reg) // [R10]
		else $error("phase error pair missing");
	a_target_term: assert property ((targ_off && !sel_start) |=> suspend_out && terminate_start) // [R11]
		else $error("target offset not suspended");
	a_overrun_runs: assert property ((overrun && !hs_timeout && !pause_req && !suspend_out && !targ_off) // [R12]
		|=> atn_out && !suspend_out) else $error("overrun handling wrong");
	a_pause_first: assert property ((pend_pause_reg && pend_offset_reg && count_reg != sier_pkg::RQ_FULL) // [R15]
		|-> push_src == SRC_PAUSE) else $error("offset report before pause report");
	a_report_stable: assert property ((count_reg != '0 && !pop) |=> $stable(head)) // [R17]
		else $error("head report changed before read");
	a_irq_level: assert property ((|(irq_stat_reg & irq_mask_reg)) |=> irq) else $error("irq not raised");
endmodule // sier_top
`default_nettype wire

// ==== sier_top_bench.sv ====
// self-checking bench for the interrupt and error report block
`timescale 1ns/1ps
`default_nettype none
module sier_top_bench;
	localparam logic [11:0] SEL = 12'h001, IDR = 12'h002, CDB = 12'h004, MSG = 12'h008, ATD = 12'h010;
	localparam logic [11:0] RDY = 12'h020, TMO = 12'h040, OFS = 12'h080, XFD = 12'h100, PHC = 12'h200, TRM = 12'h400;
	localparam logic [1:0] OK = sier_pkg::RESP_OKAY, ER = sier_pkg::RESP_SLVERR;
	// host wait: transfer cycles times block length plus 60 internal cycles
	localparam int WAIT_CYC = 2 * 4 + 60;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr, ready_code, s;
	logic [31:0] wdata, rdata, rnd;
	logic [3:0] wstrb, cmd_step, done_count, resp_type;
	logic [1:0] bresp, rresp;
	sier_pkg::sier_op_e op_state;
	logic data_request, sel_atn, is_initiator, data_phase, data_in_phase, req_over_offset, data_reg_full, to_msg_out;
	logic atn_out, suspend_out, terminate_start, pause_req, irq;
	logic [11:0] ev;
	logic [7:0] rcodes [6] = '{8'h70, 8'h01, 8'h71, 8'h80, 8'h81, 8'h90};
	int errors = 0, checks_done = 0, term_seen = 0, pause_seen = 0;
	sier_top sier_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .op_state, .cmd_step,
		.done_count, .resp_type, .data_request, .sel_start(ev[0]), .sel_atn, .identify_rx(ev[1]), .cdb_rx(ev[2]),
		.atn_msg_rx(ev[3]), .atn_detect(ev[4]), .ready_event(ev[5]), .ready_code, .is_initiator, .data_phase,
		.data_in_phase, .hs_timeout(ev[6]), .offset_err(ev[7]), .req_over_offset, .data_reg_full,
		.xfer_done(ev[8]), .phase_change(ev[9]), .to_msg_out, .terminate_done(ev[10]), .pause_done(ev[11]),
		.atn_out, .suspend_out, .terminate_start, .pause_req, .irq);
	sier_scsi_model sier_scsi_model_i (.aclk, .pause_req, .ev);
	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		if (terminate_start)
			term_seen++;
		if (pause_req)
			pause_seen++;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [7:0] step_of(input int op, input logic [3:0] cs, dc, rt);
		case (op)
			0: return {4'h0, cs};
			1: return {dc, cs};
			2: return {rt, cs};
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, got);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_pin(input string what, input logic exp, got);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask
	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		if (er === OK)
			chk(what, exp, rdata);
	endtask
	task automatic rpt(input logic [7:0] c, st);
		rd("code", 8'h10, {24'h0, c}, OK);
		rd("code again", 8'h10, {24'h0, c}, OK);
		rd("step", 8'h14, {24'h0, st}, OK);
	endtask
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, sel_atn, is_initiator, data_phase} = '0;
		{data_in_phase, req_over_offset, data_reg_full, to_msg_out} = '0;
		{awaddr, araddr, wdata, cmd_step, done_count, resp_type, ready_code} = '0;
		wstrb = 4'hf;
		data_request = 1'b1;
		op_state = sier_pkg::OP_DISCRETE;
		rnd = 32'hc632;
		tick(4);
		aresetn <= 1'b1;
		rd("irq_mask", 8'h1c, 32'h0, OK);
		rd("unmapped", 8'h40, 32'h0, ER);
		wr(8'h10, 32'h0, ER);
		rd("empty code", 8'h10, 32'h0, OK);
		wr(8'h1c, 32'h7, OK);
		rd("irq_mask", 8'h1c, 32'h7, OK);
		$display("test registers done");
		for (int i = 0; i < 4; i++)
		begin
			rnd = lfsr(rnd);
			@(posedge aclk);
			op_state <= sier_pkg::sier_op_e'(i);
			cmd_step <= rnd[3:0];
			done_count <= rnd[7:4];
			resp_type <= rnd[11:8];
			sier_scsi_model_i.fire(TMO);
			tick(4);
			chk_pin("suspend", 1'b1, suspend_out);
			rpt(sier_pkg::CODE_HS_TIMEOUT, step_of(i, rnd[3:0], rnd[7:4], rnd[11:8]));
		end
		chk_pin("irq", 1'b1, irq);
		rd("controller_status", 8'h08, 32'hc, OK);
		rd("irq_status", 8'h18, 32'h5, OK);
		wr(8'h1c, 32'h0, OK);
		tick(2);
		chk_pin("irq masked", 1'b0, irq);
		wr(8'h18, 32'h5, OK);
		rd("irq_status", 8'h18, 32'h0, OK);
		wr(8'h1c, 32'h7, OK);
		sier_scsi_model_i.fire(SEL);
		tick(2);
		chk_pin("suspend", 1'b0, suspend_out);
		chk_pin("irq", 1'b0, irq);
		op_state <= sier_pkg::OP_READY;
		foreach (rcodes[i])
		begin
			@(posedge aclk);
			ready_code <= rcodes[i];
			sier_scsi_model_i.fire(RDY);
			tick(3);
			rpt(rcodes[i], 8'h00);
		end
		$display("test steps done");
		rnd = lfsr(rnd);
		s = {rnd[7:4], rnd[3:0]};
		@(posedge aclk);
		op_state <= sier_pkg::OP_AUTO_SEL;
		cmd_step <= rnd[3:0];
		resp_type <= rnd[7:4];
		sel_atn <= 1'b1;
		sier_scsi_model_i.fire(SEL);
		sier_scsi_model_i.fire(IDR);
		sier_scsi_model_i.fire(CDB);
		sier_scsi_model_i.fire(MSG);
		sier_scsi_model_i.fire(SEL);
		sier_scsi_model_i.fire(CDB);
		sier_scsi_model_i.fire(MSG);
		sel_atn <= 1'b0;
		sier_scsi_model_i.fire(SEL);
		sier_scsi_model_i.fire(CDB);
		sier_scsi_model_i.fire(ATD);
		tick(4);
		rpt(8'ha9, s);
		rpt(8'ha8, s);
		rpt(8'haa, s);
		$display("test auto response done");
		s = {4'h0, rnd[3:0]};
		@(posedge aclk);
		op_state <= sier_pkg::OP_DISCRETE;
		is_initiator <= 1'b1;
		data_phase <= 1'b1;
		to_msg_out <= 1'b1;
		sier_scsi_model_i.fire(OFS);
		tick(2);
		chk_pin("atn", 1'b1, atn_out);
		rd("controller_status", 8'h08, 32'h6, OK);
		sier_scsi_model_i.fire(PHC);
		tick(3);
		rpt(8'h29, s);
		rd("empty code", 8'h10, 32'h0, OK);
		sier_scsi_model_i.fire(OFS);
		sier_scsi_model_i.fire(XFD);
		tick(3);
		rpt(8'h29, s);
		to_msg_out <= 1'b0;
		sier_scsi_model_i.fire(OFS);
		sier_scsi_model_i.fire(PHC);
		tick(4);
		rpt(8'h29, s);
		rpt(sier_pkg::CODE_PHASE_ERR, s);
		is_initiator <= 1'b0;
		sier_scsi_model_i.fire(OFS);
		tick(2);
		chk_pin("suspend", 1'b1, suspend_out);
		chk("terminate pulses", 32'h1, 32'(term_seen));
		rd("empty code", 8'h10, 32'h0, OK);
		sier_scsi_model_i.fire(TRM);
		tick(3);
		rpt(8'h29, s);
		sier_scsi_model_i.fire(PHC);
		tick(1);
		chk_pin("atn released", 1'b0, atn_out);
		sier_scsi_model_i.fire(SEL);
		is_initiator <= 1'b1;
		data_in_phase <= 1'b1;
		req_over_offset <= 1'b1;
		data_reg_full <= 1'b1;
		data_request <= 1'b0;
		tick(3);
		chk_pin("atn", 1'b1, atn_out);
		chk_pin("suspend", 1'b0, suspend_out);
		req_over_offset <= 1'b0;
		data_reg_full <= 1'b0;
		tick(WAIT_CYC);
		rd("controller_status", 8'h08, 32'h2, OK);
		wr(8'h20, 32'h1, OK);
		tick(12);
		chk("pause requests", 32'h1, 32'(pause_seen));
		rpt(8'h67, s);
		rpt(8'h29, s);
		rd("irq_status", 8'h18, 32'h3, OK);
		$display("test errors done");
		close_out();
	end
	// the whole sequence needs a few hundred cycles; this allows about 50000
	initial
	begin
		#400000;
		errors++;
		close_out();
	end
endmodule // sier_top_bench
`default_nettype wire
